/* File: dv/expected_config_record_writer_tb.sv */
/*
 * Self-checking bench for the expected configuration record writer.
 * Assumes ecw_pkg and the host model in host_record_model.sv.
 */
`timescale 1ns/1ns
module expected_config_record_writer_tb
    import ecw_pkg::*;
;
    logic        clock = 1'b0, resetn = 1'b0, go = 1'b0, slow = 1'b0;
    logic [8:0]  len = 9'h0ac;
    logic [7:0]  img [0:172], sav [0:172];
    logic        recValid, recStart, recLast, busy;
    logic [7:0]  recByte;
    logic [63:0] managedMask = 64'h0;
    logic        startupReq = 1'b0, paramReady = 1'b0, detValid = 1'b0;
    logic [5:0]  detAddr = 6'h00;
    logic [15:0] detCfg = 16'h0000;
    logic        recDone, recError, configMode, autoAddrEnable, paramValid, actValid, actGrant;
    logic [5:0]  paramAddr, actAddr;
    logic [3:0]  paramValue;
    logic [15:0] expRec[$], expAct[$], expPar[$];
    int          err_count = 0, compares = 0;
    always #25 clock = ~clock;
    host_record_model host (.clock(clock), .go(go), .slow(slow), .len(len), .img(img),
        .recValid(recValid), .recStart(recStart), .recLast(recLast), .recByte(recByte),
        .busy(busy));
    expected_config_record_writer dut (.clock(clock), .resetn(resetn), .recValid(recValid),
        .recStart(recStart), .recLast(recLast), .recByte(recByte), .managedMask(managedMask),
        .startupReq(startupReq), .paramReady(paramReady), .detValid(detValid),
        .detAddr(detAddr), .detCfg(detCfg), .recDone(recDone), .recError(recError),
        .configMode(configMode), .autoAddrEnable(autoAddrEnable), .paramValid(paramValid),
        .paramAddr(paramAddr), .paramValue(paramValue), .actValid(actValid),
        .actAddr(actAddr), .actGrant(actGrant));
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic give_up();
        err_count++;
        wrap_up();
    endtask
    function automatic logic [15:0] cfgOf(logic [5:0] a);
        int cb;
        cb = (a[5] ? 74 : 10) + 2 * a[4:0];
        return {img[cb], img[cb + 1]};
    endfunction
    function automatic logic grant(logic [5:0] a, logic [15:0] c, logic m);
        if (m)
            return a[4:0] != 5'h00;
        return img[2 + 4 * a[5] + a[4:3]][a[2:0]] && a != 6'h20 && cfgOf(a) == c;
    endfunction
    function automatic logic [3:0] parOf(logic [5:0] s);
        logic [7:0] b;
        b = img[(s[5] ? 154 : 138) + s[4:0] / 2];
        if (managedMask[s])
            return MANAGED_PARAM;
        return s[0] ? b[3:0] : b[7:4];
    endfunction
    task automatic send(logic [8:0] n, logic [15:0] exp);
        int k;
        len <= n;
        expRec.push_back(exp);
        go <= 1'b1;
        @(negedge clock);
        go <= 1'b0;
        repeat (2) @(negedge clock);
        for (k = 0; k < 400 && busy; k++) @(negedge clock);
        if (busy) give_up();
        repeat (3) @(negedge clock);
    endtask
    task automatic modes(logic c, logic a);
        chk("configMode", 16'(configMode), 16'(c));
        chk("autoAddrEnable", 16'(autoAddrEnable), 16'(a));
    endtask
    // Fixed addresses cover address zero in both banks and one listed slave
    task automatic dets(logic m);
        logic [5:0]  a;
        logic [15:0] c;
        for (int j = 0; j < 8; j++) begin
            a = j == 0 ? 6'h00 : j == 1 ? 6'h05 : j == 2 ? 6'h20 : 6'($urandom);
            c = $urandom % 2 ? cfgOf(a) : 16'($urandom);
            detAddr <= a;
            detCfg <= c;
            detValid <= 1'b1;
            expAct.push_back({9'h000, a, grant(a, c, m)});
            @(negedge clock);
            detValid <= 1'b0;
            @(negedge clock);
        end
    endtask
    always @(posedge clock) begin
        if (resetn && (recDone | recError) === 1'b1) begin
            if (expRec.size() == 0)
                chk("record answer", 16'h0001, 16'h0000);
            else
                chk("record answer", {14'h0, recDone, recError}, expRec.pop_front());
        end
        if (resetn && actValid === 1'b1) begin
            if (expAct.size() == 0)
                chk("activation", 16'h0001, 16'h0000);
            else
                chk("activation", {9'h0, actAddr, actGrant}, expAct.pop_front());
        end
        if (resetn && (paramValid & paramReady) === 1'b1) begin
            if (expPar.size() == 0)
                chk("parameter", 16'h0001, 16'h0000);
            else
                chk("parameter", {6'h0, paramAddr, paramValue}, expPar.pop_front());
        end
    end
    // ************************************************************
    // Stimulus
    // ************************************************************
    initial begin
        int i;
        i = $urandom(32'h4cc2);
        for (i = 0; i < 173; i++) img[i] = 8'($urandom);
        img[0] = 8'h00;
        img[1] = 8'h00;
        img[74] = 8'h00;
        img[75] = 8'h00;
        img[138][7:4] = 4'h0;
        img[154][7:4] = 4'h0;
        img[2][5] = 1'b1;
        repeat (10) @(negedge clock);
        managedMask <= {32'($urandom), 32'($urandom)};
        resetn <= 1'b1;
        @(negedge clock);
        modes(MODE_CONFIG, AUTO_DISABLED);
        // Last pass leaves protected mode with auto addressing off
        for (i = 3; i >= 0; i--) begin
            img[170] = 8'($urandom);
            img[171] = 8'($urandom);
            img[170][CFG_MODE_BIT] = i[0];
            img[171][AUTO_EN_BIT] = i[1];
            slow <= i[0];
            send(9'h0ac, 16'h0002);
            modes(i[0], i[1]);
            dets(i[0]);
        end
        sav = img;
        img[170][CFG_MODE_BIT] = 1'b1;
        for (i = 2; i < 100; i++) img[i] = ~img[i];
        send(9'h064, 16'h0001);
        send(9'h0ad, 16'h0001);
        img = sav;
        modes(MODE_PROTECTED, AUTO_DISABLED);
        dets(MODE_PROTECTED);
        resetn <= 1'b0;
        repeat (10) @(negedge clock);
        resetn <= 1'b1;
        @(negedge clock);
        modes(MODE_CONFIG, AUTO_DISABLED);
        for (i = 1; i < 64; i++)
            if (i != 32) expPar.push_back({6'h00, 6'(i), parOf(6'(i))});
        startupReq <= 1'b1;
        @(negedge clock);
        startupReq <= 1'b0;
        for (i = 0; i < 1000 && expPar.size() > 0; i++) begin
            paramReady <= $urandom % 3 != 0;
            @(negedge clock);
        end
        if (expPar.size() > 0) give_up();
        modes(MODE_PROTECTED, AUTO_DISABLED);
        chk("pending answers", 16'(expRec.size() + expAct.size()), 16'h0000);
        wrap_up();
    end
endmodule

/* File: dv/host_record_model.sv */
/*
 * Host side model: sends one configuration record byte by byte.
 * Assumes go is set off the falling edge for one cycle while idle.
 */
`timescale 1ns/1ns
module host_record_model (
    input  wire logic       clock,
    input  wire logic       go,
    input  wire logic       slow,
    input  wire logic [8:0] len,
    input  wire logic [7:0] img [0:172],
    output logic            recValid,
    output logic            recStart,
    output logic            recLast,
    output logic [7:0]      recByte,
    output logic            busy
);
    // ************************************************************
    // Byte sender
    // ************************************************************
    logic [8:0] idx = 9'h000;
    logic       gap = 1'b0;
    initial begin
        {recValid, recStart, recLast, busy} = 4'h0;
        recByte = 8'h00;
    end
    // Bytes leave in index order, so the layout is the image's own
    always @(negedge clock) begin
        gap <= slow && !gap;
        if (busy && idx < len && !gap) begin
            recValid <= 1'b1;
            recStart <= idx == 9'h000;
            recLast  <= idx == len - 9'h001;
            recByte  <= img[idx];
            idx      <= idx + 9'h001;
        end else begin
            recValid <= 1'b0;
            recStart <= 1'b0;
            recLast  <= 1'b0;
            // Released data is inverted every cycle, so it differs from the last byte only on alternate idle cycles
            recByte  <= ~recByte;
            if (idx >= len) begin
                busy <= 1'b0;
                idx  <= 9'h000;
            end else if (go) begin
                busy <= 1'b1;
            end
        end
    end
endmodule

/* File: hdl/ecw_pkg.sv */
/*
 * Constants for the expected configuration record writer: record layout,
 * flag bit positions, mode encodings, reset values and parameter sequencing.
 * Assumes a single 20 MHz clock domain and byte-wide record delivery.
 */
package ecw_pkg;

    // ************************************************************
    // Record layout (byte indices)
    // ************************************************************
    localparam int         REC_LEN        = 172;
    localparam logic [7:0] REC_LAST_IDX   = 8'hab;
    localparam logic [7:0] LIST_A_BYTE    = 8'h02;
    localparam logic [7:0] LIST_B_BYTE    = 8'h06;
    localparam logic [7:0] CFG_A_BYTE     = 8'h0a;
    // B slaves start at slave 1B, byte 76, so base is two below
    localparam logic [7:0] CFG_B_BYTE     = 8'h4a;
    localparam logic [7:0] PAR_A_BYTE     = 8'h8a;
    localparam logic [7:0] PAR_B_BYTE     = 8'h9a;
    localparam logic [7:0] FLAG1_BYTE     = 8'haa;
    localparam logic [7:0] FLAG2_BYTE     = 8'hab;

    // ************************************************************
    // Flag bits, encodings and reset values
    // ************************************************************
    localparam int         CFG_MODE_BIT   = 4;
    localparam int         AUTO_EN_BIT    = 3;
    localparam logic       MODE_PROTECTED = 1'b0;
    localparam logic       MODE_CONFIG    = 1'b1;
    localparam logic       AUTO_DISABLED  = 1'b0;
    localparam logic       AUTO_ENABLED   = 1'b1;
    localparam logic       CFG_MODE_RST   = MODE_CONFIG;
    localparam logic       AUTO_EN_RST    = AUTO_DISABLED;
    localparam logic [3:0] MANAGED_PARAM  = 4'hf;

    // ************************************************************
    // Parameter sequencing at startup
    // ************************************************************
    localparam logic [5:0] SLOT_A_FIRST   = 6'h01;
    localparam logic [5:0] SLOT_B_FIRST   = 6'h21;
    localparam logic [5:0] SLOT_B_LAST    = 6'h3f;
    localparam logic [4:0] BANK_LAST      = 5'h1f;
    localparam logic [4:0] ADDR_ZERO      = 5'h00;

    typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} seq_state_e;

endpackage

/* File: hdl/expected_config_record_writer.sv */
/*
 * Receives the expected configuration record byte by byte, keeps it as the
 * persistent expected image, applies the two mode flags, grants slave
 * activation and sends stored parameters at startup.
 * Assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/1ns
module expected_config_record_writer
    import ecw_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        recValid,
    input  wire logic        recStart,
    input  wire logic        recLast,
    input  wire logic [7:0]  recByte,
    input  wire logic [63:0] managedMask,
    input  wire logic        startupReq,
    input  wire logic        paramReady,
    input  wire logic        detValid,
    input  wire logic [5:0]  detAddr,
    input  wire logic [15:0] detCfg,
    output logic             recDone,
    output logic             recError,
    output logic             configMode,
    output logic             autoAddrEnable,
    output logic             paramValid,
    output logic [5:0]       paramAddr,
    output logic [3:0]       paramValue,
    output logic             actValid,
    output logic [5:0]       actAddr,
    output logic             actGrant
);

    // ************************************************************
    // Storage
    // ************************************************************
    // The image has no reset on purpose: it stands for the persistent
    // store and must survive resetn like the real one survives restarts.
    logic [7:0] rxBuf [REC_LEN];
    logic [7:0] image [REC_LEN];

    logic       inRec_r;
    logic [7:0] byteCnt_r;
    logic       recDone_r;
    logic       recError_r;
    logic       configMode_r;
    logic       autoAddrEnable_r;
    logic       paramValid_r;
    logic [5:0] paramAddr_r;
    logic [3:0] paramValue_r;
    logic       actValid_r;
    logic [5:0] actAddr_r;
    logic       actGrant_r;

    // ************************************************************
    // Record reception decode
    // ************************************************************
    wire       rxTake   = recValid && (recStart || inRec_r);
    wire [7:0] rxIdx    = recStart ? 8'h00 : byteCnt_r;
    wire       rxOver   = !recStart && (byteCnt_r > REC_LAST_IDX);
    wire       rxAtLast = (rxIdx == REC_LAST_IDX);
    wire       rxCommit = rxTake && recLast && !rxOver && rxAtLast;
    wire       rxBad    = rxTake && (rxOver || (recLast && !rxAtLast));
    // Version and reserved bytes are stored as sent and never checked
    wire       wrCfgMode = rxBuf[FLAG1_BYTE][CFG_MODE_BIT];
    wire       wrAutoEn  = recByte[AUTO_EN_BIT];

    always_ff @(posedge clock) begin
        if (rxTake && !rxOver) begin
            rxBuf[rxIdx] <= recByte;
        end
    end

    // A short or long record never reaches the image, so a half-written
    // configuration can not be activated
    generate
        for (genvar i = 0; i < REC_LEN; i++) begin : gCommit
            always_ff @(posedge clock) begin
                if (rxCommit) begin
                    image[i] <= (i == REC_LEN - 1) ? recByte : rxBuf[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!resetn) begin
            inRec_r    <= 1'b0;
            byteCnt_r  <= 8'h00;
            recDone_r  <= 1'b0;
            recError_r <= 1'b0;
        end else begin
            recDone_r  <= rxCommit;
            recError_r <= rxBad;
            if (rxTake) begin
                byteCnt_r <= rxOver ? byteCnt_r : rxIdx + 8'h01;
                inRec_r   <= !recLast && !rxOver;
            end
        end
    end

    // ************************************************************
    // Mode flags
    // ************************************************************
    // Only two flag bits are looked at; the rest of both flag bytes stay
    // with whatever the master keeps itself
    always_ff @(posedge clock) begin
        if (!resetn) begin
            configMode_r     <= CFG_MODE_RST;
            autoAddrEnable_r <= AUTO_EN_RST;
        end else if (rxCommit) begin
            configMode_r     <= wrCfgMode;
            autoAddrEnable_r <= wrAutoEn;
        end else if (startupReq) begin
            configMode_r     <= image[FLAG1_BYTE][CFG_MODE_BIT];
            autoAddrEnable_r <= image[FLAG2_BYTE][AUTO_EN_BIT];
        end
    end

    // ************************************************************
    // Activation check
    // ************************************************************
    wire       detIsB     = detAddr[5];
    wire       detZero    = (detAddr[4:0] == ADDR_ZERO);
    wire [7:0] listIdx    = (detIsB ? LIST_B_BYTE : LIST_A_BYTE) + {6'h00, detAddr[4:3]};
    wire       listBit    = image[listIdx][detAddr[2:0]];
    wire [7:0] cfgIdx     = (detIsB ? CFG_B_BYTE : CFG_A_BYTE)
                            + {2'b00, detAddr[4:0], 1'b0};
    wire [7:0] cfgIdxHi   = cfgIdx + 8'h01;
    // Slave 0B has no configuration bytes, so it never matches
    wire       cfgHasSlot = !(detIsB && detZero);
    wire       cfgMatch   = cfgHasSlot && ({image[cfgIdx], image[cfgIdxHi]} == detCfg);
    wire       grantProt  = listBit && cfgMatch;
    wire       grantCfg   = !detZero;
    wire       grant      = configMode_r ? grantCfg : grantProt;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            actValid_r <= 1'b0;
            actAddr_r  <= 6'h00;
            actGrant_r <= 1'b0;
        end else begin
            actValid_r <= detValid;
            actAddr_r  <= detAddr;
            actGrant_r <= detValid && grant;
        end
    end

    // ************************************************************
    // Parameter send at startup
    // ************************************************************
    logic       seqValid;
    logic [5:0] seqSlot;
    logic       seqBusy;

    wire       seqTake  = seqValid && (!paramValid_r || paramReady);
    wire [7:0] parIdx   = (seqSlot[5] ? PAR_B_BYTE : PAR_A_BYTE) + {4'h0, seqSlot[4:1]};
    // Odd slaves sit in the low nibble, even ones in the high nibble
    wire [3:0] parRaw   = seqSlot[0] ? image[parIdx][3:0] : image[parIdx][7:4];
    wire       managed  = managedMask[seqSlot];
    wire [3:0] parSend  = managed ? MANAGED_PARAM : parRaw;

    param_sequencer uSeq (
        .clock  (clock),
        .resetn (resetn),
        .start  (startupReq),
        .take   (seqTake),
        .valid  (seqValid),
        .slot   (seqSlot),
        .busy   (seqBusy)
    );

    // One output stage holds each parameter until the slave side accepts it
    always_ff @(posedge clock) begin
        if (!resetn) begin
            paramValid_r <= 1'b0;
            paramAddr_r  <= 6'h00;
            paramValue_r <= 4'h0;
        end else if (!paramValid_r || paramReady) begin
            paramValid_r <= seqValid;
            paramAddr_r  <= seqSlot;
            paramValue_r <= parSend;
        end
    end

    assign recDone        = recDone_r;
    assign recError       = recError_r;
    assign configMode     = configMode_r;
    assign autoAddrEnable = autoAddrEnable_r;
    assign paramValid     = paramValid_r;
    assign paramAddr      = paramAddr_r;
    assign paramValue     = paramValue_r;
    assign actValid       = actValid_r;
    assign actAddr        = actAddr_r;
    assign actGrant       = actGrant_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // A held last slot from an earlier send would delay the first one
    sequence s_startIdle;
        startupReq && !seqBusy && !paramValid;
    endsequence

    sequence s_firstParam;
        paramValid && (paramAddr == SLOT_A_FIRST);
    endsequence

    sequence s_paramHeld;
        paramValid && !paramReady;
    endsequence

    sequence s_paramStands;
        paramValid && $stable(paramAddr) && $stable(paramValue);
    endsequence

    sequence s_lastTaken;
        paramValid && paramReady && (paramAddr == SLOT_B_LAST) && !seqBusy;
    endsequence

    a_commit_image_last: assert property (rxCommit
                                          |=> image[FLAG2_BYTE] == $past(recByte) && recDone)
        else $error("Committed record not stored in image");

    a_flag_bytes_kept: assert property (rxCommit
                                        |=> image[FLAG1_BYTE] == $past(rxBuf[FLAG1_BYTE]))
        else $error("First flag byte not stored in image");

    a_bad_length: assert property (rxBad
                                   |=> recError && !recDone)
        else $error("Record of wrong length not rejected");

    a_image_kept: assert property (rxBad
                                   |=> $stable(image[FLAG1_BYTE]) && $stable(image[CFG_A_BYTE]))
        else $error("Rejected record changed the stored image");

    a_write_mode_flags: assert property (rxCommit
                                         |=> configMode == $past(wrCfgMode)
                                         && autoAddrEnable == $past(wrAutoEn))
        else $error("Written mode flags not applied");

    a_other_flags_ignored: assert property (!rxCommit && !startupReq
                                            |=> $stable(configMode) && $stable(autoAddrEnable))
        else $error("Mode changed without a flag write or startup");

    a_mode_retained: assert property (startupReq && !rxCommit
                                      |=> configMode == $past(image[FLAG1_BYTE][CFG_MODE_BIT]))
        else $error("Operating mode not restored from image");

    a_auto_retained: assert property (startupReq && !rxCommit
                                      |=> autoAddrEnable == $past(image[FLAG2_BYTE][AUTO_EN_BIT]))
        else $error("Auto address enable not restored from image");

    a_act_answer: assert property (detValid
                                   |=> actValid && actAddr == $past(detAddr))
        else $error("Detected slave query not answered");

    a_config_zero_denied: assert property (detValid && configMode && detZero
                                           |=> actValid && !actGrant)
        else $error("Address zero activated in configuration mode");

    a_config_grant: assert property (detValid && configMode && !detZero
                                     |=> actGrant)
        else $error("Nonzero slave refused in configuration mode");

    a_protect_grant: assert property (detValid && !configMode && listBit && cfgMatch
                                      |=> actGrant)
        else $error("Listed matching slave refused in protected mode");

    a_protect_mismatch: assert property (detValid && !configMode && !cfgMatch |=> !actGrant)
        else $error("Mismatching slave activated in protected mode");

    a_protect_unlisted: assert property (detValid && !configMode && !listBit |=> !actGrant)
        else $error("Unlisted slave activated in protected mode");

    a_param_hold: assert property (s_paramHeld
                                   |=> s_paramStands)
        else $error("Parameter changed before it was accepted");

    a_bank_switch: assert property (seqTake && (seqSlot == {1'b0, BANK_LAST})
                                    |=> seqSlot == SLOT_B_FIRST)
        else $error("Parameter send did not move on to the B bank");

    a_send_done: assert property (s_lastTaken
                                  |=> !paramValid)
        else $error("Parameter send did not stop after the last slot");

    a_managed_param: assert property (seqTake && managed |=> paramValue == MANAGED_PARAM)
        else $error("Managed slave parameter not forced to F");

    a_startup_params: assert property (s_startIdle |-> ##2 s_firstParam)
        else $error("Parameter send did not start after startup");

endmodule

/* File: hdl/param_sequencer.sv */
/*
 * Walks the slave parameter slots 1..31 then 1B..31B once per start.
 * Assumes the caller pulses take whenever it consumes the current slot.
 */
`timescale 1ns/1ns
module param_sequencer
    import ecw_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       start,
    input  wire logic       take,
    output logic            valid,
    output logic [5:0]      slot,
    output logic            busy
);

    seq_state_e state_r;
    logic [5:0] slot_r;

    assign valid = (state_r == SEQ_RUN);
    assign busy  = (state_r == SEQ_RUN);
    assign slot  = slot_r;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_r <= SEQ_IDLE;
            slot_r  <= SLOT_A_FIRST;
        end else begin
            case (state_r)
                SEQ_IDLE: begin
                    if (start) begin
                        state_r <= SEQ_RUN;
                        slot_r  <= SLOT_A_FIRST;
                    end
                end
                SEQ_RUN: begin
                    if (take) begin
                        if (slot_r == SLOT_B_LAST) begin
                            state_r <= SEQ_IDLE;
                        end else if (slot_r[4:0] == BANK_LAST) begin
                            slot_r <= SLOT_B_FIRST;
                        end else begin
                            slot_r <= slot_r + 6'h01;
                        end
                    end
                end
                default: begin
                    state_r <= SEQ_IDLE;
                end
            endcase
        end
    end

endmodule
